// ==== hdl/sspr_consts.vh ====
// Overview of operation
// - select 000 means no signature compression
// - select 001 uses polynomial one
// - select 010 uses polynomial two
// - select 011 uses polynomial three
// - seed is low word 08, high 09
// - result is low word 0a, high 0b
// - index write loads four shared pointers
// - shared pointers advance by four after each long-word access, except in a cycle with an index write
// - vector pointer write at 11
// - header/trailer pointer write at 13
// - macro pointer write at 15
// - sequencer pointer write at 17
// - bridge-support pointer write at 19
`ifndef SSPR_CONSTS_VH
`define SSPR_CONSTS_VH

// register indices; byte address is four times the index
`define SSPR_IDX_POLY      5'h07
`define SSPR_IDX_SEED_LO   5'h08
`define SSPR_IDX_SEED_HI   5'h09
`define SSPR_IDX_RES_LO    5'h0a
`define SSPR_IDX_RES_HI    5'h0b
`define SSPR_IDX_SHARED    5'h0c
`define SSPR_IDX_VECTOR    5'h11
`define SSPR_IDX_HDRTRL    5'h13
`define SSPR_IDX_MACRO     5'h15
`define SSPR_IDX_SEQ       5'h17
`define SSPR_IDX_BRIDGE    5'h19

`define SSPR_POLY_MSB      2
`define SSPR_POLY_NONE     3'h0
`define SSPR_POLY_1        3'h1
`define SSPR_POLY_2        3'h2
`define SSPR_POLY_3        3'h3

// feedback taps below x^32, x^0 included
`define SSPR_TAPS_1        32'h000000af
`define SSPR_TAPS_2        32'h18000003
`define SSPR_TAPS_3        32'h000000c5

`define SSPR_RESET_16      16'h0000
`define SSPR_RESET_32      32'h00000000
`define SSPR_PTR_STEP      16'h0004

`endif

// ==== hdl/sspr_regs.v ====
`timescale 1ns/10ps
`include "sspr_consts.vh"

module sspr_regs (
    input  wire        clk,               // system clock
    input  wire        reset,             // synchronous, active high
    input  wire        psel,              // apb select
    input  wire        penable,           // apb access phase
    input  wire        pwrite,            // apb direction
    input  wire [7:0]  paddr,             // apb byte address
    input  wire [31:0] pwdata,            // apb write data
    output wire [31:0] prdata,            // apb read data
    output wire        pready,            // apb ready
    output wire        pslverr,           // apb error, unmapped address
    input  wire        scan_in_valid,     // captured scan-in bit strobe
    input  wire        scan_in_bit,       // captured scan-in bit
    input  wire        scan_in_rd_lw,     // long-word read of scan-in space
    input  wire        scan_out_wr_lw,    // long-word write of scan-out space
    input  wire        expected_wr_lw,    // long-word write of expected space
    input  wire        mask_wr_lw,        // long-word write of mask space
    output wire [2:0]  lfsr_poly_select,  // active polynomial
    output wire [31:0] signature,         // running signature
    output wire [15:0] scan_out_ptr,      // scan-out memory pointer
    output wire [15:0] scan_in_ptr,       // scan-in memory pointer
    output wire [15:0] expected_ptr,      // expected memory pointer
    output wire [15:0] mask_ptr,          // mask memory pointer
    output wire [15:0] vector_pointer,    // vector area pointer
    output wire [15:0] header_trailer_pointer, // header/trailer area pointer
    output wire [15:0] macro_pointer,     // macro area pointer
    output wire [15:0] sequencer_pointer, // sequencer area pointer
    output wire [15:0] bridge_support_pointer  // bridge-support area pointer
);

////////////////////////////////////////////////////////////////////////////////
function [31:0] taps_of;
    input [2:0] sel;
    begin
        case (sel)
            `SSPR_POLY_1: taps_of = `SSPR_TAPS_1;
            `SSPR_POLY_2: taps_of = `SSPR_TAPS_2;
            `SSPR_POLY_3: taps_of = `SSPR_TAPS_3;
            default:      taps_of = `SSPR_RESET_32;
        endcase
    end
endfunction

function mapped;
    input [4:0] idx;
    begin
        case (idx)
            `SSPR_IDX_POLY, `SSPR_IDX_SEED_LO, `SSPR_IDX_SEED_HI,
            `SSPR_IDX_RES_LO, `SSPR_IDX_RES_HI, `SSPR_IDX_SHARED,
            `SSPR_IDX_VECTOR, `SSPR_IDX_HDRTRL, `SSPR_IDX_MACRO,
            `SSPR_IDX_SEQ, `SSPR_IDX_BRIDGE: mapped = 1'b1;
            default:                          mapped = 1'b0;
        endcase
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
reg  [2:0]  poly_ff;
reg  [31:0] seed_ff;
reg  [31:0] lfsr_ff;
reg  [15:0] so_ptr_ff;
reg  [15:0] si_ptr_ff;
reg  [15:0] ex_ptr_ff;
reg  [15:0] mk_ptr_ff;
reg  [15:0] vec_ff;
reg  [15:0] ht_ff;
reg  [15:0] mac_ff;
reg  [15:0] seq_ff;
reg  [15:0] brg_ff;
reg  [31:0] prdata_ff;
reg  [31:0] nxt_prdata;
reg         pready_ff;
reg         pslverr_ff;

wire [4:0]  idx     = paddr[6:2];
wire        addr_ok = (paddr[7] == 1'b0) && (paddr[1:0] == 2'b00) && mapped(idx);
// one wait state: ready rises on the first access edge, the transfer ends on the second
wire        access  = psel && penable && !pready_ff;
wire        commit  = psel && penable && pready_ff;
wire        wr      = commit && pwrite && addr_ok;
wire [15:0] wd      = pwdata[15:0];

// galois shift of the captured bit
wire        shift_en = scan_in_valid && (poly_ff != `SSPR_POLY_NONE);
wire        fb       = lfsr_ff[31] ^ scan_in_bit;
wire [31:0] lfsr_sh  = {lfsr_ff[30:0], 1'b0} ^ (fb ? taps_of(poly_ff) : `SSPR_RESET_32);

////////////////////////////////////////////////////////////////////////////////
always @* begin
    nxt_prdata = `SSPR_RESET_32;
    case (idx)
        `SSPR_IDX_POLY:    nxt_prdata[`SSPR_POLY_MSB:0] = poly_ff;
        `SSPR_IDX_SEED_LO: nxt_prdata[15:0] = seed_ff[15:0];
        `SSPR_IDX_SEED_HI: nxt_prdata[15:0] = seed_ff[31:16];
        `SSPR_IDX_RES_LO:  nxt_prdata[15:0] = lfsr_ff[15:0];
        `SSPR_IDX_RES_HI:  nxt_prdata[15:0] = lfsr_ff[31:16];
        `SSPR_IDX_SHARED:  nxt_prdata[15:0] = so_ptr_ff;
        `SSPR_IDX_VECTOR:  nxt_prdata[15:0] = vec_ff;
        `SSPR_IDX_HDRTRL:  nxt_prdata[15:0] = ht_ff;
        `SSPR_IDX_MACRO:   nxt_prdata[15:0] = mac_ff;
        `SSPR_IDX_SEQ:     nxt_prdata[15:0] = seq_ff;
        `SSPR_IDX_BRIDGE:  nxt_prdata[15:0] = brg_ff;
        default:           nxt_prdata = `SSPR_RESET_32;
    endcase
    if (!addr_ok || pwrite) begin
        nxt_prdata = `SSPR_RESET_32;
    end
end

always @(posedge clk) begin
    if (reset) begin
        pready_ff  <= 1'b0;
        pslverr_ff <= 1'b0;
        prdata_ff  <= `SSPR_RESET_32;
    end else begin
        pready_ff  <= access;
        pslverr_ff <= access && !addr_ok;
        prdata_ff  <= access ? nxt_prdata : `SSPR_RESET_32;
    end
end

////////////////////////////////////////////////////////////////////////////////
// register writes; reserved bits never stored
always @(posedge clk) begin
    if (reset) begin
        poly_ff <= 3'h0;
        seed_ff <= `SSPR_RESET_32;
        vec_ff  <= `SSPR_RESET_16;
        ht_ff   <= `SSPR_RESET_16;
        mac_ff  <= `SSPR_RESET_16;
        seq_ff  <= `SSPR_RESET_16;
        brg_ff  <= `SSPR_RESET_16;
    end else if (wr) begin
        case (idx)
            `SSPR_IDX_POLY:    poly_ff        <= pwdata[`SSPR_POLY_MSB:0];
            `SSPR_IDX_SEED_LO: seed_ff[15:0]  <= wd;
            `SSPR_IDX_SEED_HI: seed_ff[31:16] <= wd;
            `SSPR_IDX_VECTOR:  vec_ff         <= wd;
            `SSPR_IDX_HDRTRL:  ht_ff          <= wd;
            `SSPR_IDX_MACRO:   mac_ff         <= wd;
            `SSPR_IDX_SEQ:     seq_ff         <= wd;
            `SSPR_IDX_BRIDGE:  brg_ff         <= wd;
            default:           poly_ff        <= poly_ff;
        endcase
    end
end

// the seed is taken when its high half lands, closing the pair;
// a captured bit in the same cycle as a result write wins so no bit is lost
always @(posedge clk) begin
    if (reset) begin
        lfsr_ff <= `SSPR_RESET_32;
    end else if (shift_en) begin
        lfsr_ff <= lfsr_sh;
    end else if (wr && idx == `SSPR_IDX_SEED_HI) begin
        lfsr_ff <= {wd, seed_ff[15:0]};
    end else if (wr && idx == `SSPR_IDX_RES_LO) begin
        lfsr_ff[15:0] <= wd;
    end else if (wr && idx == `SSPR_IDX_RES_HI) begin
        lfsr_ff[31:16] <= wd;
    end
end

////////////////////////////////////////////////////////////////////////////////
// shared pointers: an index write beats a same-cycle advance
wire load_shared = wr && (idx == `SSPR_IDX_SHARED);

always @(posedge clk) begin
    if (reset) begin
        so_ptr_ff <= `SSPR_RESET_16;
        si_ptr_ff <= `SSPR_RESET_16;
        ex_ptr_ff <= `SSPR_RESET_16;
        mk_ptr_ff <= `SSPR_RESET_16;
    end else if (load_shared) begin
        so_ptr_ff <= wd;
        si_ptr_ff <= wd;
        ex_ptr_ff <= wd;
        mk_ptr_ff <= wd;
    end else begin
        if (scan_out_wr_lw) so_ptr_ff <= so_ptr_ff + `SSPR_PTR_STEP;
        if (scan_in_rd_lw)  si_ptr_ff <= si_ptr_ff + `SSPR_PTR_STEP;
        if (expected_wr_lw) ex_ptr_ff <= ex_ptr_ff + `SSPR_PTR_STEP;
        if (mask_wr_lw)     mk_ptr_ff <= mk_ptr_ff + `SSPR_PTR_STEP;
    end
end

////////////////////////////////////////////////////////////////////////////////
assign prdata                 = prdata_ff;
assign pready                 = pready_ff;
assign pslverr                = pslverr_ff;
assign lfsr_poly_select       = poly_ff;
assign signature              = lfsr_ff;
assign scan_out_ptr           = so_ptr_ff;
assign scan_in_ptr            = si_ptr_ff;
assign expected_ptr           = ex_ptr_ff;
assign mask_ptr               = mk_ptr_ff;
assign vector_pointer         = vec_ff;
assign header_trailer_pointer = ht_ff;
assign macro_pointer          = mac_ff;
assign sequencer_pointer      = seq_ff;
assign bridge_support_pointer = brg_ff;

endmodule

// ==== tb/sspr_checker_properties.sv ====
`timescale 1ns/10ps
module sspr_checker (
    input wire        clk, reset, psel, penable, pwrite, pready, pslverr, // apb
    input wire [7:0]  paddr,                                         // address
    input wire [31:0] pwdata, prdata, signature,                     // data
    input wire        scan_in_valid, scan_in_bit, scan_in_rd_lw,     // scan strobes
    input wire [2:0]  lfsr_poly_select,                              // polynomial
    input wire [15:0] scan_in_ptr, vector_pointer                    // pointers
);
    default clocking @(posedge clk); endclocking
    default disable iff (reset);
    wire acc = psel && penable && pready;
    ////////////////////////////////////////////////////////////////////////////
    property p_wait; psel && penable && !pready |=> pready; endproperty
    a_wait: assert property (p_wait) else $error("pready late");
    property p_pulse; pready |=> !pready; endproperty
    a_pulse: assert property (p_pulse) else $error("pready held");
    property p_upper; pready |-> prdata[31:16] == 16'h0000; endproperty
    a_upper: assert property (p_upper) else $error("upper read bits set");
    property p_polyrd; pready && !pwrite && paddr == 8'h1c |-> prdata[31:3] == 29'h0; endproperty
    a_polyrd: assert property (p_polyrd) else $error("reserved bits set");
    property p_hold; lfsr_poly_select == 3'h0 && !psel |=> $stable(signature); endproperty
    a_hold: assert property (p_hold) else $error("signature moved");
    property p_shift1;
        lfsr_poly_select == 3'h1 && scan_in_valid && !psel |=> signature ==
        ({$past(signature[30:0]), 1'b0} ^
         (($past(signature[31]) ^ $past(scan_in_bit)) ? 32'h000000af : 32'h0));
    endproperty
    a_shift1: assert property (p_shift1) else $error("bad shift");
    property p_sin; scan_in_rd_lw && !(acc && pwrite) |=>
        scan_in_ptr == $past(scan_in_ptr) + 16'h0004; endproperty
    a_sin: assert property (p_sin) else $error("scan-in pointer stuck");
    property p_vec; acc && pwrite && paddr == 8'h44 |=>
        vector_pointer == $past(pwdata[15:0]); endproperty
    a_vec: assert property (p_vec) else $error("vector pointer not loaded");
endmodule
bind sspr_regs sspr_checker u_chk (.clk(clk), .reset(reset), .psel(psel),
    .penable(penable), .pwrite(pwrite), .pready(pready), .pslverr(pslverr),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .signature(signature),
    .scan_in_valid(scan_in_valid), .scan_in_bit(scan_in_bit),
    .scan_in_rd_lw(scan_in_rd_lw), .lfsr_poly_select(lfsr_poly_select),
    .scan_in_ptr(scan_in_ptr), .vector_pointer(vector_pointer));

// ==== tb/sspr_apb_master.sv ====
`timescale 1ns/10ps
module sspr_apb_master (
    input wire         clk,     // system clock
    output logic       psel,    // select
    output logic       penable, // access phase
    output logic       pwrite,  // direction
    output logic [7:0] paddr,   // byte address
    output logic [31:0] pwdata, // write data
    input wire [31:0]  prdata,  // read data
    input wire         pready,  // ready
    input wire         pslverr  // error
);
    initial {psel, penable, pwrite, paddr, pwdata} = '0;
    // starts one edge later so a release and a new setup never share a step;
    // waits for ready without a limit, the bench watchdog ends a hang
    task automatic xfer(input logic w, input logic [7:0] a, input logic [31:0] d,
                        output logic [31:0] r, output logic e);
        @(posedge clk);
        psel <= 1'b1; pwrite <= w; paddr <= a; pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do begin
            @(posedge clk);
        end while (pready !== 1'b1);
        r = prdata;
        e = pslverr;
        psel <= 1'b0; penable <= 1'b0;
    endtask
endmodule

// ==== tb/test_signature_and_pointer_registers.sv ====
`timescale 1ns/10ps
module test_signature_and_pointer_registers;
    logic clk = 0, reset = 1, sv = 0, sb = 0, srd = 0, sow = 0, ew = 0, mw = 0;
    int errors = 0, n_checks = 0;
    wire psel, penable, pwrite, pready, pslverr;
    wire [7:0] paddr;
    wire [31:0] pwdata, prdata, sig;
    wire [15:0] so_p, si_p, ex_p, mk_p, vec_p, ht_p, mc_p, sq_p, bs_p;
    wire [2:0] ps;
    logic [7:0] ad [11] = '{8'h1c, 8'h20, 8'h24, 8'h28, 8'h2c, 8'h30, 8'h44, 8'h4c,
                            8'h54, 8'h5c, 8'h64};
    logic [31:0] tp [4] = '{32'h0, 32'h000000af, 32'h18000003, 32'h000000c5};
    always #50 clk = ~clk;
    sspr_apb_master m (.clk(clk), .psel(psel), .penable(penable), .pwrite(pwrite),
        .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr));
    sspr_regs uut (.clk(clk), .reset(reset), .psel(psel), .penable(penable),
        .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
        .pslverr(pslverr), .scan_in_valid(sv), .scan_in_bit(sb), .scan_in_rd_lw(srd),
        .scan_out_wr_lw(sow), .expected_wr_lw(ew), .mask_wr_lw(mw), .lfsr_poly_select(ps),
        .signature(sig), .scan_out_ptr(so_p), .scan_in_ptr(si_p), .expected_ptr(ex_p),
        .mask_ptr(mk_p), .vector_pointer(vec_p), .header_trailer_pointer(ht_p),
        .macro_pointer(mc_p), .sequencer_pointer(sq_p), .bridge_support_pointer(bs_p));
    ////////////////////////////////////////////////////////////////////////////
    task chk(input logic [31:0] seen, input logic [31:0] exp);
        n_checks++;
        if (seen !== exp) begin
            errors++;
            $display("wrong value at %0t: %h, expected %h", $time, seen, exp);
        end
    endtask
    task rd(input logic [7:0] a, input logic [31:0] e);
        logic [31:0] r;
        logic x;
        m.xfer(1'b0, a, 32'h0, r, x);
        chk(r, e);
    endtask
    task wr(input logic [7:0] a, input logic [31:0] d);
        logic [31:0] r;
        logic x;
        m.xfer(1'b1, a, d, r, x);
    endtask
    task wrap_up;
        $display("checks %0d, mismatches %0d", n_checks, errors);
        if (errors == 0 && n_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    ////////////////////////////////////////////////////////////////////////////
    task t_reset;
        foreach (ad[i]) rd(ad[i], 32'h0);
        chk(sig, 32'h0);
        $display("reset values done");
    endtask
    // aligned values only, as software must load them
    task t_ptrs;
        for (int i = 5; i < 11; i++) wr(ad[i], 32'h100 + 16 * i);
        for (int i = 5; i < 11; i++) rd(ad[i], 32'h100 + 16 * i);
        chk(vec_p, 32'h160);
        chk({ht_p, mc_p}, 32'h01700180);
        chk({sq_p, bs_p}, 32'h019001a0);
        @(posedge clk) {srd, sow, ew, mw} <= 4'hf;
        @(posedge clk) {srd, sow, ew, mw} <= 4'h0;
        @(negedge clk);
        chk({so_p, si_p}, 32'h01540154);
        chk({ex_p, mk_p}, 32'h01540154);
        $display("pointer test done");
    endtask
    task t_poly;
        logic [31:0] r;
        logic x;
        wr(8'h1c, 32'hffffffff);
        rd(8'h1c, 32'h7);
        chk(ps, 32'h7);
        m.xfer(1'b0, 8'h18, 32'h0, r, x);
        chk(x, 32'h1);
        $display("select and unmapped done");
    endtask
    task t_lfsr;
        logic [31:0] s;
        logic b;
        for (int p = 0; p < 4; p++) begin
            wr(8'h1c, p);
            wr(8'h20, 32'h1234 + p);
            wr(8'h24, 32'hc0de);
            s = {16'hc0de, 16'h1234 + p[15:0]};
            for (int k = 0; k < 9; k++) begin
                b = k[0] ^ k[2];
                @(posedge clk) begin sv <= 1'b1; sb <= b; end
                if (p > 0) s = {s[30:0], 1'b0} ^ ((s[31] ^ b) ? tp[p] : 32'h0);
            end
            @(posedge clk) sv <= 1'b0;
            rd(8'h28, s[15:0]);
            rd(8'h2c, s[31:16]);
        end
        wr(8'h28, 32'h5a5a);
        rd(8'h28, 32'h5a5a);
        $display("signature test done");
    endtask
    ////////////////////////////////////////////////////////////////////////////
    initial begin
        #(100 * 5000);
        errors++;
        wrap_up;
    end
    initial begin
        repeat (6) @(posedge clk);
        reset <= 1'b0;
        t_reset;
        t_ptrs;
        t_poly;
        t_lfsr;
        wrap_up;
    end
endmodule
